// *** rtl/acl_top.sv ***
// Command list control: sample-time byte, indices, base pointer, fetch and store engine.
// Assumes same-clock memory port and a single-cycle register port.
//
// Notes on behaviour
// - Reserved setting in loaded command sets error flag and halts conversions.
// - Sample-time byte always readable, writable only under special mode access.
// - Sample code bits 15:11 give code plus four clocks; above 20 reserved.
// - Conversion clock period comes from the seven-bit prescaler setting.
// - Read-only six-bit command index counts 32-bit commands within list.
// - Base pointer bits 23:2 writable only when disabled or special access.
// - Fetch address built from base pointer and active list.
// - Read-only six-bit result index counts 16-bit results within list.
// - Byte after sample-time byte has no function and reads zero.
//
// The plain strobed port was left to the implementer.
`include "acl_defs.svh"
module acl_top
  import acl_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Interrupt
  output logic IRQ,
  // List selection and result base
  input wire logic ACTIVE_LIST,
  input wire logic [6:0] LIST1_OFFSET,
  input wire logic [23:0] RES_BASE,
  // Command fetch
  output logic FETCH_REQ,
  output logic [23:0] FETCH_ADDR,
  input wire logic FETCH_VALID,
  input wire logic [31:0] FETCH_DATA,
  // Result store
  output logic STORE_REQ,
  output logic [23:0] STORE_ADDR
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic cmd_bad(input logic [31:0] c);
    cmd_bad = (c[15:11] > `ACL_SMP_MAX) || (c[10:0] != 11'h000);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  acl_state_type st_q, st_d;
  logic en_q, en_d, smod_q, smod_d;
  logic [6:0] prs_q, prs_d, pcnt_q, pcnt_d;
  logic [5:0] scnt_q, scnt_d;
  logic [7:0] smpb_q, smpb_d;
  logic [21:0] cbp_q, cbp_d;
  logic [5:0] cidx_q, cidx_d, ridx_q, ridx_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic [23:0] faddr_q, faddr_d, saddr_q, saddr_d;
  logic tick;
  logic [1:0] ev;

  assign tick = (pcnt_q == prs_q);

  always_comb begin
    st_d = st_q;
    en_d = en_q;
    smod_d = smod_q;
    prs_d = prs_q;
    pcnt_d = tick ? 7'h00 : pcnt_q + 7'h01;
    scnt_d = scnt_q;
    smpb_d = smpb_q;
    cbp_d = cbp_q;
    cidx_d = cidx_q;
    ridx_d = ridx_q;
    mask_d = mask_q;
    ev = 2'b00;
    rdata_d = 8'h00;
    // Fetch address follows index and list; a command is 32 bits wide
    faddr_d = {cbp_q, 2'b00}
      + {14'h0000, (ACTIVE_LIST ? {1'b0, LIST1_OFFSET} : 8'h00), 2'b00}
      + {16'h0000, cidx_q, 2'b00};
    saddr_d = RES_BASE + {17'h00000, ridx_q, 1'b0};
    // Software port
    if (WR) begin
      if (hit(ADDR, `ACL_OFF_CTRL)) begin
        en_d = WDATA[`ACL_CTRL_EN];
        smod_d = WDATA[`ACL_CTRL_SMOD];
      end
      if (hit(ADDR, `ACL_OFF_PRS)) begin
        prs_d = WDATA[6:0];
      end
      if (hit(ADDR, `ACL_OFF_MASK)) begin
        mask_d = WDATA[1:0];
      end
      if (hit(ADDR, `ACL_OFF_SMPB) && smod_q) begin
        smpb_d = WDATA;
      end
      // Low byte drops bits 1:0, since a command is always word aligned
      if (hit(ADDR, `ACL_OFF_CBP0) && (!en_q || smod_q)) begin
        cbp_d[5:0] = WDATA[7:2];
      end
      if (hit(ADDR, `ACL_OFF_CBP1) && (!en_q || smod_q)) begin
        cbp_d[13:6] = WDATA;
      end
      if (hit(ADDR, `ACL_OFF_CBP2) && (!en_q || smod_q)) begin
        cbp_d[21:14] = WDATA;
      end
    end
    if (RD) begin
      case (ADDR)
        `ACL_OFF_CTRL: rdata_d = {6'h00, smod_q, en_q};
        `ACL_OFF_PRS: rdata_d = {1'b0, prs_q};
        `ACL_OFF_STAT: rdata_d = {6'h00, stat_q};
        `ACL_OFF_MASK: rdata_d = {6'h00, mask_q};
        `ACL_OFF_SMPB: rdata_d = smpb_q;
        `ACL_OFF_RSVB: rdata_d = 8'h00;
        `ACL_OFF_CIDX: rdata_d = {2'b00, cidx_q};
        `ACL_OFF_CBP0: rdata_d = {cbp_q[5:0], 2'b00};
        `ACL_OFF_CBP1: rdata_d = cbp_q[13:6];
        `ACL_OFF_CBP2: rdata_d = cbp_q[21:14];
        `ACL_OFF_RIDX: rdata_d = {2'b00, ridx_q};
        default: rdata_d = 8'h00;
      endcase
    end
    // Engine
    case (st_q)
      ST_IDLE: begin
        cidx_d = `ACL_RST_IDX;
        ridx_d = `ACL_RST_IDX;
        if (en_q) begin
          st_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (FETCH_VALID) begin
          smpb_d = FETCH_DATA[15:8];
          scnt_d = 6'h00;
          if (cmd_bad(FETCH_DATA)) begin
            ev[`ACL_ST_CERR] = 1'b1;
            st_d = ST_HALT;
          end else begin
            st_d = ST_SAMPLE;
          end
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          // Sample lasts code plus four conversion clocks
          if (scnt_q == {1'b0, smpb_q[7:3]} + `ACL_SMP_BASE - 6'h01) begin
            st_d = ST_STORE;
          end else begin
            scnt_d = scnt_q + 6'h01;
          end
        end
      end
      ST_STORE: begin
        ev[`ACL_ST_DONE] = 1'b1;
        cidx_d = cidx_q + 6'h01;
        ridx_d = ridx_q + 6'h01;
        st_d = ST_FETCH;
      end
      ST_HALT: begin
        // Halt holds until software takes the enable away
      end
      default: st_d = ST_IDLE;
    endcase
    if (!en_q) begin
      st_d = ST_IDLE;
    end
    // Set beats a simultaneous write-one clear
    stat_d = stat_q;
    if (WR && hit(ADDR, `ACL_OFF_STAT)) begin
      stat_d = stat_q & ~WDATA[1:0];
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      st_q <= ST_IDLE;
      en_q <= 1'b0;
      smod_q <= 1'b0;
      prs_q <= `ACL_RST_PRS;
      pcnt_q <= 7'h00;
      scnt_q <= 6'h00;
      smpb_q <= `ACL_RST_BYTE;
      cbp_q <= `ACL_RST_CBP;
      cidx_q <= `ACL_RST_IDX;
      ridx_q <= `ACL_RST_IDX;
      stat_q <= 2'b00;
      mask_q <= 2'b00;
      rdata_q <= 8'h00;
      faddr_q <= 24'h000000;
      saddr_q <= 24'h000000;
    end else begin
      st_q <= st_d;
      en_q <= en_d;
      smod_q <= smod_d;
      prs_q <= prs_d;
      pcnt_q <= pcnt_d;
      scnt_q <= scnt_d;
      smpb_q <= smpb_d;
      cbp_q <= cbp_d;
      cidx_q <= cidx_d;
      ridx_q <= ridx_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      faddr_q <= faddr_d;
      saddr_q <= saddr_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RDATA = rdata_q;
  assign IRQ = |(stat_q & mask_q);
  assign FETCH_REQ = (st_q == ST_FETCH);
  assign FETCH_ADDR = faddr_q;
  assign STORE_REQ = (st_q == ST_STORE);
  assign STORE_ADDR = saddr_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_err_halt;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (FETCH_REQ && FETCH_VALID && cmd_bad(FETCH_DATA) && en_q)
      |=> (st_q == ST_HALT) && stat_q[`ACL_ST_CERR] ##1 !FETCH_REQ;
  endproperty
  a_err_halt: assert property (p_err_halt) else $error("bad command not halted");

  property p_smpb_lock;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (WR && ADDR == `ACL_OFF_SMPB && !smod_q && st_q != ST_FETCH) |=> $stable(smpb_q);
  endproperty
  a_smpb_lock: assert property (p_smpb_lock) else $error("sample byte written unlocked");

  property p_smp_len;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (st_q == ST_SAMPLE && tick && scnt_q < {1'b0, smpb_q[7:3]} + 6'h03 && en_q)
      |=> (st_q == ST_SAMPLE);
  endproperty
  a_smp_len: assert property (p_smp_len) else $error("sample ended early");

  property p_tick;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      tick && prs_q == 7'h02 && $stable(prs_q) |=> !tick ##1 !tick;
  endproperty
  a_tick: assert property (p_tick) else $error("conversion clock period wrong");

  property p_fetch_addr;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      FETCH_REQ && $stable(cidx_q) && $stable(cbp_q) && !ACTIVE_LIST && !$past(ACTIVE_LIST)
      |-> FETCH_ADDR == {cbp_q, 2'b00} + {16'h0000, cidx_q, 2'b00};
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");

  property p_store;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      STORE_REQ && en_q |=> ridx_q == $past(ridx_q) + 6'h01 && cidx_q == $past(cidx_q) + 6'h01;
  endproperty
  a_store: assert property (p_store) else $error("indices not advanced");

  property p_rsv;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      RD && ADDR == `ACL_OFF_RSVB |=> RDATA == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved byte not zero");

  property p_cbp_lock;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      WR && en_q && !smod_q |=> $stable(cbp_q);
  endproperty
  a_cbp_lock: assert property (p_cbp_lock) else $error("pointer written while enabled");

  property p_cbp_map;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      WR && ADDR == `ACL_OFF_CBP1 && (!en_q || smod_q) |=> cbp_q[13:6] == $past(WDATA);
  endproperty
  a_cbp_map: assert property (p_cbp_map) else $error("pointer byte misplaced");

  property p_cidx_rd;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      RD && ADDR == `ACL_OFF_CIDX |=> RDATA == {2'b00, $past(cidx_q)};
  endproperty
  a_cidx_rd: assert property (p_cidx_rd) else $error("command index read wrong");

  property p_store_addr;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      STORE_REQ && $stable(RES_BASE) |-> STORE_ADDR == RES_BASE + {17'h00000, ridx_q, 1'b0};
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("store address wrong");

endmodule

// *** rtl/acl_defs.svh ***
// Offsets, field positions, reset values and timing counts of the command list block.
// Assumes byte-wide register port with byte addresses.
`ifndef ACL_DEFS_SVH
`define ACL_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACL_OFF_CTRL 8'h00
`define ACL_OFF_PRS 8'h01
`define ACL_OFF_STAT 8'h02
`define ACL_OFF_MASK 8'h03
`define ACL_OFF_SMPB 8'h16
`define ACL_OFF_RSVB 8'h17
`define ACL_OFF_CIDX 8'h1C
`define ACL_OFF_CBP0 8'h1D
`define ACL_OFF_CBP1 8'h1E
`define ACL_OFF_CBP2 8'h1F
`define ACL_OFF_RIDX 8'h20
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define ACL_CTRL_EN 0
`define ACL_CTRL_SMOD 1
`define ACL_ST_CERR 0
`define ACL_ST_DONE 1
`define ACL_SMP_MAX 5'h14
`define ACL_SMP_BASE 6'h04
`define ACL_RST_BYTE 8'h00
`define ACL_RST_PRS 7'h00
`define ACL_RST_CBP 22'h000000
`define ACL_RST_IDX 6'h00
`endif

// *** rtl/acl_pkg.sv ***
// Types of the command list block.
// Assumes nothing beyond the compiler.
package acl_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_SAMPLE, ST_STORE, ST_HALT} acl_state_type;
endpackage

// *** sim/acl_mem_model.sv ***
// Memory holding the command lists: answers fetches after a set latency.
// Assumes the fetch port of the command list block on the same clock.
module acl_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fetch port
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  output logic fetch_valid,
  output logic [31:0] fetch_data,
  // Store strobe and latency control
  input wire logic store_req,
  input wire integer lat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:63];
  logic [23:0] last_addr;
  int cnt, cyc, acc, dur;
  initial begin
    fetch_valid = 1'b0;
    fetch_data = 32'h5A5A_5A5A;
    cnt = 0;
    cyc = 0;
    acc = 0;
    dur = 0;
  end
  // ----------------------------------------
  // Answer and measure
  // ----------------------------------------
  // Data toggles while idle so a stale word can never pass for a fresh one
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fetch_valid && fetch_req) begin
      acc <= cyc;
      last_addr <= fetch_addr;
    end
    if (store_req) dur <= cyc - acc;
    if (!rst_n || !fetch_req || fetch_valid) begin
      cnt <= 0;
      fetch_valid <= 1'b0;
      fetch_data <= ~fetch_data;
    end else if (cnt >= lat) begin
      fetch_valid <= 1'b1;
      fetch_data <= mem[fetch_addr[7:2]];
    end else begin
      cnt <= cnt + 1;
      fetch_data <= ~fetch_data;
    end
  end
endmodule

// *** sim/acl_top_tb_top.sv ***
// Self-checking bench of the command list block.
// Assumes the memory model on the fetch port and a 10 MHz clock.
`include "acl_defs.svh"
module acl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset_n = 0, wr = 0, rd = 0, active_list = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, rv;
  logic irq, fetch_req, fetch_valid, store_req;
  logic [6:0] list1_offset = 7'h03;
  logic [23:0] res_base = 24'h004000, fetch_addr, store_addr;
  logic [31:0] fetch_data;
  int lat = 1, fail_count = 0, n_tests = 0, i, lo, hi;
  int code [3] = '{0, 20, 3};
  always #50 clk_sys = ~clk_sys;
  acl_top DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .IRQ(irq), .ACTIVE_LIST(active_list),
    .LIST1_OFFSET(list1_offset), .RES_BASE(res_base), .FETCH_REQ(fetch_req),
    .FETCH_ADDR(fetch_addr), .FETCH_VALID(fetch_valid), .FETCH_DATA(fetch_data),
    .STORE_REQ(store_req), .STORE_ADDR(store_addr));
  acl_mem_model MEM (.clk(clk_sys), .rst_n(reset_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .store_req(store_req), .lat(lat));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 rv = rdata;
    chk(rv, e);
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    #(20000 * 100);
    fail_count++;
    report_and_stop;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    for (i = 0; i < 64; i++) MEM.mem[i] = 32'h0;
    MEM.mem[1] = 32'h0000_A000;
    MEM.mem[2] = 32'h0000_1800;
    MEM.mem[3] = 32'h0000_A800;
    MEM.mem[4] = 32'h0000_0001;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rchk(`ACL_OFF_RSVB, 8'h00);
    rchk(`ACL_OFF_CIDX, 8'h00);
    rchk(`ACL_OFF_RIDX, 8'h00);
    rchk(8'h40, 8'h00);
    wr_reg(`ACL_OFF_SMPB, 8'hA0);
    rchk(`ACL_OFF_SMPB, 8'h00);
    wr_reg(`ACL_OFF_CTRL, 8'h02);
    wr_reg(`ACL_OFF_SMPB, 8'hA0);
    rchk(`ACL_OFF_SMPB, 8'hA0);
    wr_reg(`ACL_OFF_RSVB, 8'hFF);
    rchk(`ACL_OFF_RSVB, 8'h00);
    wr_reg(`ACL_OFF_CIDX, 8'hFF);
    rchk(`ACL_OFF_CIDX, 8'h00);
    wr_reg(`ACL_OFF_CTRL, 8'h00);
    wr_reg(`ACL_OFF_CBP0, 8'hFF);
    rchk(`ACL_OFF_CBP0, 8'hFC);
    wr_reg(`ACL_OFF_CBP0, 8'h00);
    wr_reg(8'h1E, 8'h01);
    wr_reg(`ACL_OFF_PRS, 8'h02);
    wr_reg(`ACL_OFF_CTRL, 8'h01);
    // Prompt and slow memory answers alternate
    for (i = 0; i < 3; i++) begin
      lat = (i == 1) ? 5 : 1;
      lo = 0;
      while (store_req !== 1'b1 && lo < 500) begin
        @(posedge clk_sys);
        #1 lo++;
      end
      chk(store_req, 1'b1);
      chk(store_addr, res_base + i * 2);
      chk(MEM.last_addr, 24'h000100 + i * 4);
      @(posedge clk_sys);
      // Code plus four ticks of three clocks; the first tick may lie one to three clocks away
      #1 lo = (code[i] + 3) * 3 + 2;
      hi = (code[i] + 3) * 3 + 4;
      chk(MEM.dur >= lo && MEM.dur <= hi, 1);
    end
    repeat (30) @(posedge clk_sys);
    rchk(`ACL_OFF_STAT, 8'h03);
    chk({fetch_req, irq}, 2'b00);
    chk(MEM.last_addr, 24'h00010C);
    rchk(`ACL_OFF_CIDX, 8'h03);
    rchk(`ACL_OFF_RIDX, 8'h03);
    wr_reg(`ACL_OFF_MASK, 8'h01);
    #1 chk(irq, 1'b1);
    wr_reg(`ACL_OFF_STAT, 8'h01);
    rchk(`ACL_OFF_STAT, 8'h02);
    chk(irq, 1'b0);
    wr_reg(8'h1F, 8'h55);
    rchk(8'h1F, 8'h00);
    wr_reg(`ACL_OFF_CTRL, 8'h03);
    wr_reg(8'h1F, 8'h55);
    rchk(8'h1F, 8'h55);
    wr_reg(8'h1F, 8'h00);
    wr_reg(`ACL_OFF_CTRL, 8'h00);
    // Indices clear only once the engine is back in idle
    @(posedge clk_sys);
    rchk(`ACL_OFF_CIDX, 8'h00);
    // Second list: offset points at a word with reserved low bits
    @(posedge clk_sys);
    active_list <= 1'b1;
    list1_offset <= 7'h04;
    wr_reg(`ACL_OFF_CTRL, 8'h01);
    repeat (20) @(posedge clk_sys);
    chk(MEM.last_addr, 24'h000110);
    rchk(`ACL_OFF_STAT, 8'h03);
    chk({fetch_req, irq}, 2'b01);
    report_and_stop;
  end
endmodule
